// file: hw/fmc_params.svh
// Register indices, field positions, reset values and timing for the fan monitor config bank
`ifndef FMC_PARAMS_SVH
`define FMC_PARAMS_SVH

// Register indices (byte address is four times the index)
`define FMC_IDX_STATUS 6'h00
`define FMC_IDX_CTRL 6'h01
`define FMC_IDX_FANS 6'h03
`define FMC_IDX_PINFN 6'h05
`define FMC_IDX_ALARM 6'h07
`define FMC_IDX_HOTPLUG 6'h08

// Global control fields
`define FMC_CTRL_INSTALL 0
`define FMC_CTRL_INT_MASK 1
`define FMC_CTRL_ARA_DIS 2
`define FMC_CTRL_FW_TEST 3
`define FMC_CTRL_START 4
`define FMC_CTRL_FORCE_CF 5
`define FMC_CTRL_FORCE_INT 6
`define FMC_CTRL_INT_POL 7

// Fans-in-system fields
`define FMC_FANS_FAN1 0
`define FMC_FANS_FAN2 1

// Status fields
`define FMC_STAT_INT 0
`define FMC_STAT_CF_IN 1
`define FMC_STAT_CF_OUT 2
`define FMC_STAT_ALARM 3
`define FMC_STAT_HOTPLUG 4

// Pin-function fields
`define FMC_PIN_GP_LO 0
`define FMC_PIN_GP_HI 2
`define FMC_PIN_D1_LO 3
`define FMC_PIN_D1_HI 4
`define FMC_PIN_D2_LO 5
`define FMC_PIN_D2_HI 6

// Reset values and masks
`define FMC_CTRL_RST 8'h00
`define FMC_CTRL_WMASK 8'hfe
`define FMC_FANS_RST 8'h01
`define FMC_FANS_WMASK 8'h03
`define FMC_PINFN_RST 8'h07
`define FMC_PINFN_WMASK 8'h7f
`define FMC_SPEED_WMASK 8'h03
`define FMC_SPEED_RST 8'h00

// Strap capture delay after reset release, in cycles
`define FMC_STRAP_WAIT 2'h3

// Free-wheel test duration
`define FMC_FW_TEST_S 10
`define FMC_CLK_HZ 100000000

// AXI responses
`define FMC_RESP_OKAY 2'h0
`define FMC_RESP_SLVERR 2'h2

`endif

// file: hw/fmc_pkg.sv
// Types shared by the fan monitor config bank
`default_nettype none
package fmc_pkg;
   // One register byte
   typedef logic [7:0] fmc_byte_t;
   // Per-fan request pair, bit 0 fan 1, bit 1 fan 2
   typedef logic [1:0] fmc_fan_t;
   // Pin function select bits 0..6
   typedef logic [6:0] fmc_pin_t;
   // Strap capture sequence
   typedef enum logic [1:0] {FMC_BOOT, FMC_LOAD, FMC_RUN} fmc_init_t;
endpackage
`default_nettype wire

// file: hw/fmc_regs.sv
// Configuration register bank of the dual-fan monitor with AXI4-Lite access
// Contract
// - Control bit 0 mirrors fan-2-installed bit.
// - Control bit 1 masks the interrupt output.
// - Control bit 2 disables alert response.
// - Control bit 3 starts free-wheel test, pausing monitoring.
// - Test bit self-clears after about ten seconds.
// - Control bit 4 starts round-robin monitoring.
// - Monitoring stopped drives all fans alarm speed.
// - Start bit resets from automatic-control strap.
// - Control bit 5 forces cascade fault low.
// - Control bit 6 forces interrupt asserted.
// - Control bit 7 selects interrupt polarity.
// - Pin bits 0-1 reset 1; 0 selects analog.
// - Pin bit 2 resets 1, writable.
// - Pin bits 3-4 reset from diode-1 detection.
// - Pin bits 5-6 reset from diode-2 detection.
// - Reserved bits always read zero.
// - Alarm request bits drive fans alarm speed.
// - Hot-plug request bits drive fans hot-plug speed unless at alarm speed.
// - Control resets zero except strap bits 0, 4.
// - Pin register resets 0????111.
// - Fan-2-installed loads from strap, stays writable.
// - Status bit shows any fan at alarm speed.
`include "fmc_params.svh"
`default_nettype none
module fmc_regs #(
   parameter int ADDR_W = 8,
   parameter longint FW_TEST_CYCLES = longint'(`FMC_FW_TEST_S) * `FMC_CLK_HZ
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic arst_n,
   // AXI4-Lite write address
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // AXI4-Lite write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read address
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // AXI4-Lite read data
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Strap and detection pins
   input wire logic auto_start_strap_pin,
   input wire logic remote_diode_1,
   input wire logic remote_diode_2,
   // Event sources from the monitor core
   input wire logic int_request,
   input wire logic fault_request,
   input wire logic cascade_fault_in_n,
   // Interrupt, fault and alert outputs
   output logic int_out,
   output logic cascade_fault_n,
   output logic ara_respond_en,
   // Monitoring control
   output logic monitor_run,
   output logic fw_test_busy,
   // Fan speed selects
   output fmc_pkg::fmc_fan_t fan_alarm,
   output fmc_pkg::fmc_fan_t fan_hotplug,
   // Pin function selects
   output fmc_pkg::fmc_pin_t pin_function
);
   import fmc_pkg::*;

   // Test length in cycles, counter wide enough for it
   localparam int FW_W = $clog2(FW_TEST_CYCLES + 1);

   // Elaboration checks
   if (ADDR_W < 8 || ADDR_W > 32) begin : g_bad_addr
      $error("ADDR_W must be 8..32");
   end
   if (FW_TEST_CYCLES < 2) begin : g_bad_fw
      $error("FW_TEST_CYCLES must be at least 2");
   end

   // Two-stage synchronisers for pins
   logic [2:0] pin_s1_q, pin_s2_q;
   logic cf_in_s1_q, cf_in_s2_q;
   // Register storage
   fmc_byte_t ctrl_q;
   fmc_fan_t fans_q, alarm_q, hotplug_q;
   fmc_pin_t pin_q;
   // Free-wheel test counter
   logic [FW_W-1:0] fw_cnt_q;
   // Strap capture sequencing
   fmc_init_t init_q;
   logic [1:0] wait_q;
   // Write channel state
   logic aw_held_q, w_held_q, wstrb0_q, bvalid_q;
   logic [ADDR_W-1:0] awaddr_q;
   fmc_byte_t wdata_q;
   logic [1:0] bresp_q;
   // Read channel state
   logic rvalid_q;
   logic [31:0] rdata_q;
   logic [1:0] rresp_q;
   // Internal decode and datapath
   logic wr_fire, wr_hit, wr_ctrl, int_asserted, cf_out, rd_hit, fw_done, fw_set;
   logic [5:0] wr_idx, rd_idx;
   fmc_byte_t status_rd, ctrl_rd, rd_byte;

   // Synchronise strap, diode and cascade pins
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         pin_s1_q <= 3'h0;
         pin_s2_q <= 3'h0;
         cf_in_s1_q <= 1'b1;
         cf_in_s2_q <= 1'b1;
      end else begin
         pin_s1_q <= {remote_diode_2, remote_diode_1, auto_start_strap_pin};
         pin_s2_q <= pin_s1_q;
         cf_in_s1_q <= cascade_fault_in_n;
         cf_in_s2_q <= cf_in_s1_q;
      end
   end

   // Wait for synchronised straps, then load once
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         init_q <= FMC_BOOT;
         wait_q <= 2'h0;
      end else begin
         case (init_q)
            FMC_BOOT: begin
               wait_q <= wait_q + 2'h1;
               if (wait_q == `FMC_STRAP_WAIT - 2'h1) begin
                  init_q <= FMC_LOAD;
               end
            end
            FMC_LOAD: init_q <= FMC_RUN;
            FMC_RUN: init_q <= FMC_RUN;
            default: init_q <= FMC_BOOT;
         endcase
      end
   end

   // Bus write decode, reserved positions masked off
   assign wr_fire = aw_held_q && w_held_q && !bvalid_q;
   assign wr_idx = awaddr_q[7:2];
   assign wr_hit = (wr_idx == `FMC_IDX_CTRL) || (wr_idx == `FMC_IDX_FANS) ||
                   (wr_idx == `FMC_IDX_PINFN) || (wr_idx == `FMC_IDX_ALARM) ||
                   (wr_idx == `FMC_IDX_HOTPLUG);
   assign wr_ctrl = wr_fire && wstrb0_q && (wr_idx == `FMC_IDX_CTRL);

   // Global control register, straps loaded once after release
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         ctrl_q <= `FMC_CTRL_RST;
      end else if (init_q == FMC_LOAD) begin
         ctrl_q[`FMC_CTRL_START] <= pin_s2_q[0];
      end else if (wr_ctrl) begin
         ctrl_q <= wdata_q & `FMC_CTRL_WMASK;
         // Running test cannot be cancelled; expiry clears unless relaunched
         ctrl_q[`FMC_CTRL_FW_TEST] <= (ctrl_q[`FMC_CTRL_FW_TEST] && !fw_done) | fw_set;
      end else if (fw_done) begin
         ctrl_q[`FMC_CTRL_FW_TEST] <= 1'b0;
      end
   end

   // Launch request from software
   assign fw_set = wdata_q[`FMC_CTRL_FW_TEST];

   // Free-wheel test timer
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         fw_cnt_q <= '0;
      end else if (wr_ctrl && fw_set && (!ctrl_q[`FMC_CTRL_FW_TEST] || fw_done)) begin
         fw_cnt_q <= FW_W'(FW_TEST_CYCLES - 1);
      end else if (ctrl_q[`FMC_CTRL_FW_TEST] && fw_cnt_q != '0) begin
         fw_cnt_q <= fw_cnt_q - FW_W'(1);
      end
   end
   assign fw_done = ctrl_q[`FMC_CTRL_FW_TEST] && (fw_cnt_q == '0);

   // Fans-in-system; control bit 0 writes the same storage
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         fans_q <= fmc_fan_t'(`FMC_FANS_RST);
      end else if (init_q == FMC_LOAD) begin
         fans_q[`FMC_FANS_FAN2] <= pin_s2_q[0];
      end else if (wr_fire && wstrb0_q && wr_idx == `FMC_IDX_FANS) begin
         fans_q <= fmc_fan_t'(wdata_q & `FMC_FANS_WMASK);
      end else if (wr_ctrl) begin
         fans_q[`FMC_FANS_FAN2] <= wdata_q[`FMC_CTRL_INSTALL];
      end
   end

   // Pin-function register, diode detection loaded once
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         pin_q <= fmc_pin_t'(`FMC_PINFN_RST);
      end else if (init_q == FMC_LOAD) begin
         pin_q[`FMC_PIN_D1_HI:`FMC_PIN_D1_LO] <= {2{!pin_s2_q[1]}};
         pin_q[`FMC_PIN_D2_HI:`FMC_PIN_D2_LO] <= {2{!pin_s2_q[2]}};
      end else if (wr_fire && wstrb0_q && wr_idx == `FMC_IDX_PINFN) begin
         pin_q <= fmc_pin_t'(wdata_q & `FMC_PINFN_WMASK);
      end
   end

   // Alarm and hot-plug speed request registers
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         alarm_q <= fmc_fan_t'(`FMC_SPEED_RST);
         hotplug_q <= fmc_fan_t'(`FMC_SPEED_RST);
      end else if (wr_fire && wstrb0_q) begin
         if (wr_idx == `FMC_IDX_ALARM) begin
            alarm_q <= fmc_fan_t'(wdata_q & `FMC_SPEED_WMASK);
         end
         if (wr_idx == `FMC_IDX_HOTPLUG) begin
            hotplug_q <= fmc_fan_t'(wdata_q & `FMC_SPEED_WMASK);
         end
      end
   end

   // Fan speed selection, alarm overrides hot-plug
   assign fan_alarm = alarm_q | {2{!ctrl_q[`FMC_CTRL_START]}};
   assign fan_hotplug = hotplug_q & ~fan_alarm;

   // Monitoring runs when started and no test is active
   assign monitor_run = ctrl_q[`FMC_CTRL_START] && !ctrl_q[`FMC_CTRL_FW_TEST];
   assign fw_test_busy = ctrl_q[`FMC_CTRL_FW_TEST];

   // Interrupt level with mask, force and polarity
   assign int_asserted = (int_request && !ctrl_q[`FMC_CTRL_INT_MASK]) ||
                         ctrl_q[`FMC_CTRL_FORCE_INT];
   assign int_out = ctrl_q[`FMC_CTRL_INT_POL] ? int_asserted : !int_asserted;

   // Cascade fault and alert response
   assign cf_out = fault_request || ctrl_q[`FMC_CTRL_FORCE_CF];
   assign cascade_fault_n = !cf_out;
   assign ara_respond_en = !ctrl_q[`FMC_CTRL_ARA_DIS];
   assign pin_function = pin_q;

   // Read views of status and control
   always_comb begin
      status_rd = 8'h00;
      status_rd[`FMC_STAT_INT] = int_asserted;
      status_rd[`FMC_STAT_CF_IN] = !cf_in_s2_q;
      status_rd[`FMC_STAT_CF_OUT] = cf_out;
      status_rd[`FMC_STAT_ALARM] = |fan_alarm;
      status_rd[`FMC_STAT_HOTPLUG] = |fan_hotplug;
      ctrl_rd = ctrl_q;
      ctrl_rd[`FMC_CTRL_INSTALL] = fans_q[`FMC_FANS_FAN2];
   end

   // Read multiplexer, reserved bits zero
   assign rd_idx = s_axi_araddr[7:2];
   always_comb begin
      rd_byte = 8'h00;
      rd_hit = 1'b1;
      case (rd_idx)
         `FMC_IDX_STATUS: rd_byte = status_rd;
         `FMC_IDX_CTRL: rd_byte = ctrl_rd;
         `FMC_IDX_FANS: rd_byte = {6'h00, fans_q};
         `FMC_IDX_PINFN: rd_byte = {1'b0, pin_q};
         `FMC_IDX_ALARM: rd_byte = {6'h00, alarm_q};
         `FMC_IDX_HOTPLUG: rd_byte = {6'h00, hotplug_q};
         default: rd_hit = 1'b0;
      endcase
   end

   // Write address and data capture, either order
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         aw_held_q <= 1'b0;
         w_held_q <= 1'b0;
         awaddr_q <= '0;
         wdata_q <= 8'h00;
         wstrb0_q <= 1'b0;
      end else if (wr_fire) begin
         aw_held_q <= 1'b0;
         w_held_q <= 1'b0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held_q <= 1'b1;
            awaddr_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held_q <= 1'b1;
            wdata_q <= s_axi_wdata[7:0];
            wstrb0_q <= s_axi_wstrb[0];
         end
      end
   end

   // Ready until captured; writes held off until straps loaded
   assign s_axi_awready = !aw_held_q && !bvalid_q && (init_q == FMC_RUN);
   assign s_axi_wready = !w_held_q && !bvalid_q && (init_q == FMC_RUN);

   // Write response one cycle after both halves held
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         bvalid_q <= 1'b0;
         bresp_q <= `FMC_RESP_OKAY;
      end else if (wr_fire) begin
         bvalid_q <= 1'b1;
         bresp_q <= wr_hit ? `FMC_RESP_OKAY : `FMC_RESP_SLVERR;
      end else if (s_axi_bready) begin
         bvalid_q <= 1'b0;
      end
   end
   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;

   // Read answer one cycle after the address
   assign s_axi_arready = !rvalid_q;
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         rvalid_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
         rresp_q <= `FMC_RESP_OKAY;
      end else if (s_axi_arvalid && !rvalid_q) begin
         rvalid_q <= 1'b1;
         rdata_q <= {24'h00_0000, rd_byte};
         rresp_q <= rd_hit ? `FMC_RESP_OKAY : `FMC_RESP_SLVERR;
      end else if (s_axi_rready) begin
         rvalid_q <= 1'b0;
      end
   end
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata = rdata_q;
   assign s_axi_rresp = rresp_q;

   // Control bit 0 read back always matches fan-2 install
   install_mirror_a: assert property (@(posedge core_clk) disable iff (!arst_n)
      (s_axi_arvalid && s_axi_arready && rd_idx == `FMC_IDX_CTRL)
      |=> s_axi_rdata[`FMC_CTRL_INSTALL] == $past(fans_q[`FMC_FANS_FAN2]))
      else $error("control bit 0 differs from fan 2 install");

   // Masked interrupt shows deasserted level unless forced
   int_mask_a: assert property (@(posedge core_clk) disable iff (!arst_n)
      (ctrl_q[`FMC_CTRL_INT_MASK] && !ctrl_q[`FMC_CTRL_FORCE_INT])
      |-> int_out == !ctrl_q[`FMC_CTRL_INT_POL])
      else $error("interrupt not suppressed by mask");

   // Forced interrupt shows asserted level of chosen polarity
   int_force_a: assert property (@(posedge core_clk) disable iff (!arst_n)
      ctrl_q[`FMC_CTRL_FORCE_INT] |-> int_out == ctrl_q[`FMC_CTRL_INT_POL])
      else $error("forced interrupt at wrong level");

   // Alert response turns off when the disable bit rises
   ara_gate_a: assert property (@(posedge core_clk) disable iff (!arst_n)
      $rose(ctrl_q[`FMC_CTRL_ARA_DIS]) |-> !ara_respond_en)
      else $error("alert response not disabled");

   // Test launch holds and pauses monitoring
   fw_pause_a: assert property (@(posedge core_clk) disable iff (!arst_n)
      $rose(fw_test_busy) |-> (fw_test_busy && !monitor_run) [*2])
      else $error("monitoring not paused during test");

   // Test bit falls only when the timer has expired
   fw_clear_a: assert property (@(posedge core_clk) disable iff (!arst_n)
      $fell(fw_test_busy) |-> $past(fw_cnt_q) == '0)
      else $error("test ended before its time");

   // Stopped monitoring forces both fans to alarm speed
   stop_alarm_a: assert property (@(posedge core_clk) disable iff (!arst_n)
      !ctrl_q[`FMC_CTRL_START] |-> fan_alarm == 2'h3 && fan_hotplug == 2'h0)
      else $error("fans not at alarm speed while stopped");

   // Forced cascade fault drives the pin low
   cf_force_a: assert property (@(posedge core_clk) disable iff (!arst_n)
      ctrl_q[`FMC_CTRL_FORCE_CF] |-> !cascade_fault_n)
      else $error("cascade fault not forced low");

   // Reserved read bits of the pin-function register are zero
   rsvd_zero_a: assert property (@(posedge core_clk) disable iff (!arst_n)
      (s_axi_arvalid && s_axi_arready && rd_idx == `FMC_IDX_PINFN)
      |=> s_axi_rdata[31:7] == '0)
      else $error("reserved bits read nonzero");

   // Alarm priority and status view
   speed_prio_a: assert property (@(posedge core_clk) disable iff (!arst_n)
      (fan_alarm & fan_hotplug) == 2'h0 && status_rd[`FMC_STAT_ALARM] == |(alarm_q | fan_alarm))
      else $error("alarm and hot-plug overlap");

   // Write response follows both halves by one cycle
   wr_resp_a: assert property (@(posedge core_clk) disable iff (!arst_n)
      wr_fire |=> s_axi_bvalid && (s_axi_bresp == `FMC_RESP_OKAY) == $past(wr_hit))
      else $error("write response missing or wrong");
endmodule
`default_nettype wire

// file: verification/fmc_core_model.sv
// Far-side model: board straps and monitor core event lines
`default_nettype none
module fmc_core_model (
   // Clock
   input wire logic core_clk,
   // Board setting from the bench: straps 5:3, events 2:0
   input wire logic [5:0] cfg,
   // Strap and detection pins
   output logic auto_start_strap_pin,
   output logic remote_diode_1,
   output logic remote_diode_2,
   // Core event lines
   output logic int_request,
   output logic fault_request,
   output logic cascade_fault_in_n
);
   timeunit 1ns;
   timeprecision 1ps;
   // Straps are static board levels
   assign {auto_start_strap_pin, remote_diode_1, remote_diode_2} = cfg[5:3];
   // Core events launch on the core clock
   always_ff @(posedge core_clk) begin
      {int_request, fault_request, cascade_fault_in_n} <= cfg[2:0];
   end
endmodule
`default_nettype wire

// file: verification/tb.sv
// Self-checking bench for the fan monitor config bank
`include "fmc_params.svh"
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import fmc_pkg::*;
   // Short free-wheel test so the run stays brief
   localparam longint FW = 20;
   localparam logic [7:0] A_STAT = {`FMC_IDX_STATUS, 2'h0};
   localparam logic [7:0] A_CTRL = {`FMC_IDX_CTRL, 2'h0};
   localparam logic [7:0] A_FANS = {`FMC_IDX_FANS, 2'h0};
   localparam logic [7:0] A_PIN = {`FMC_IDX_PINFN, 2'h0};
   localparam logic [7:0] A_ALRM = {`FMC_IDX_ALARM, 2'h0};
   localparam logic [7:0] A_HP = {`FMC_IDX_HOTPLUG, 2'h0};
   localparam logic [1:0] OK = `FMC_RESP_OKAY;
   localparam logic [1:0] ERR = `FMC_RESP_SLVERR;
   // Clock, reset and bus
   logic core_clk = 1'h0;
   logic arst_n = 1'h0;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
   logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata;
   // Pins and block outputs
   logic auto_start_strap_pin, remote_diode_1, remote_diode_2;
   logic int_request, fault_request, cascade_fault_in_n;
   logic int_out, cascade_fault_n, ara_respond_en, monitor_run, fw_test_busy;
   fmc_fan_t fan_alarm, fan_hotplug;
   fmc_pin_t pin_function;
   logic [5:0] cfg = 6'h31;
   int n_mismatch = 0;
   int check_count = 0;
   int cyc = 0;

   fmc_regs #(.ADDR_W(8), .FW_TEST_CYCLES(FW)) u_dut (
      .core_clk(core_clk), .arst_n(arst_n),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
      .auto_start_strap_pin(auto_start_strap_pin), .remote_diode_1(remote_diode_1),
      .remote_diode_2(remote_diode_2), .int_request(int_request), .fault_request(fault_request),
      .cascade_fault_in_n(cascade_fault_in_n), .int_out(int_out), .cascade_fault_n(cascade_fault_n),
      .ara_respond_en(ara_respond_en), .monitor_run(monitor_run), .fw_test_busy(fw_test_busy),
      .fan_alarm(fan_alarm), .fan_hotplug(fan_hotplug), .pin_function(pin_function)
   );

   fmc_core_model u_core (
      .core_clk(core_clk), .cfg(cfg), .auto_start_strap_pin(auto_start_strap_pin),
      .remote_diode_1(remote_diode_1), .remote_diode_2(remote_diode_2), .int_request(int_request),
      .fault_request(fault_request), .cascade_fault_in_n(cascade_fault_in_n)
   );

   // 100 MHz clock
   always #5 core_clk = ~core_clk;

   // Hang guard, far above the run length
   always @(posedge core_clk) begin
      cyc = cyc + 1;
      if (cyc == 3000) begin
         n_mismatch++;
         summarize();
      end
   end

   // Compare one value
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Bus write; waits for the response and checks its code
   task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
      @(posedge core_clk);
      s_axi_awaddr <= a;
      s_axi_awvalid <= 1'h1;
      s_axi_wdata <= {24'h0, d};
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      do begin
         @(posedge core_clk);
         if (s_axi_awready) s_axi_awvalid <= 1'h0;
         if (s_axi_wready) s_axi_wvalid <= 1'h0;
      end while (!s_axi_bvalid);
      s_axi_bready <= 1'h0;
      chk("bresp", 32'(er), 32'(s_axi_bresp));
   endtask

   // Bus read; checks data and response code
   task automatic rc(input string what, input logic [7:0] a, input logic [7:0] e, input logic [1:0] er);
      @(posedge core_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      do begin
         @(posedge core_clk);
         if (s_axi_arready) s_axi_arvalid <= 1'h0;
      end while (!s_axi_rvalid);
      s_axi_rready <= 1'h0;
      chk(what, {24'h0, e}, s_axi_rdata);
      chk("rresp", 32'(er), 32'(s_axi_rresp));
   endtask

   // Power-up with given straps: auto, diode 1, diode 2
   task automatic boot(input logic [2:0] straps);
      cfg <= {straps, 3'h1};
      arst_n <= 1'h0;
      repeat (2) @(posedge core_clk);
      arst_n <= 1'h1;
      repeat (6) @(posedge core_clk);
   endtask

   // Counts and verdict
   task automatic summarize();
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // Main sequence
   initial begin
      // Auto control on, diode 1 attached, diode 2 absent
      boot(3'h6);
      rc("ctrl", A_CTRL, 8'h11, OK);
      rc("fans", A_FANS, 8'h03, OK);
      rc("pin", A_PIN, 8'h67, OK);
      rc("alarm", A_ALRM, 8'h00, OK);
      rc("hotplug", A_HP, 8'h00, OK);
      chk("monitor_run", 32'h1, 32'(monitor_run));
      chk("fan_alarm", 32'h0, 32'(fan_alarm));
      // Install bit seen through control bit 0
      wr(A_FANS, 8'h01, OK);
      rc("ctrl", A_CTRL, 8'h10, OK);
      // Pin-function writes, reserved bit ignored
      wr(A_PIN, 8'hff, OK);
      rc("pin", A_PIN, 8'h7f, OK);
      wr(A_PIN, 8'h00, OK);
      chk("pin_function", 32'h0, 32'(pin_function));
      // Speed requests and their priority
      wr(A_ALRM, 8'hff, OK);
      rc("alarm", A_ALRM, 8'h03, OK);
      wr(A_HP, 8'hff, OK);
      rc("hotplug", A_HP, 8'h03, OK);
      chk("fan_alarm", 32'h3, 32'(fan_alarm));
      chk("fan_hotplug", 32'h0, 32'(fan_hotplug));
      rc("status", A_STAT, 8'h08, OK);
      wr(A_ALRM, 8'h02, OK);
      chk("fan_alarm", 32'h2, 32'(fan_alarm));
      chk("fan_hotplug", 32'h1, 32'(fan_hotplug));
      wr(A_ALRM, 8'h00, OK);
      rc("status", A_STAT, 8'h10, OK);
      chk("fan_hotplug", 32'h3, 32'(fan_hotplug));
      // Interrupt output with an active source
      cfg <= 6'h35;
      wr(A_CTRL, 8'h10, OK);
      chk("int_out", 32'h0, 32'(int_out));
      wr(A_CTRL, 8'h12, OK);
      chk("int_out", 32'h1, 32'(int_out));
      wr(A_CTRL, 8'h90, OK);
      chk("int_out", 32'h1, 32'(int_out));
      // Forced interrupt with the source quiet
      cfg <= 6'h31;
      wr(A_CTRL, 8'h50, OK);
      chk("int_out", 32'h0, 32'(int_out));
      wr(A_CTRL, 8'hd0, OK);
      chk("int_out", 32'h1, 32'(int_out));
      // Alert response disable and forced fault
      wr(A_CTRL, 8'h14, OK);
      chk("ara_respond_en", 32'h0, 32'(ara_respond_en));
      chk("int_out", 32'h1, 32'(int_out));
      wr(A_CTRL, 8'h30, OK);
      chk("cascade_fault_n", 32'h0, 32'(cascade_fault_n));
      chk("ara_respond_en", 32'h1, 32'(ara_respond_en));
      wr(A_CTRL, 8'h10, OK);
      chk("cascade_fault_n", 32'h1, 32'(cascade_fault_n));
      cfg <= 6'h32;
      repeat (3) @(posedge core_clk);
      chk("cascade_fault_n", 32'h0, 32'(cascade_fault_n));
      rc("status", A_STAT, 8'h16, OK);
      cfg <= 6'h31;
      // Monitoring stopped forces alarm speed
      wr(A_CTRL, 8'h00, OK);
      chk("fan_alarm", 32'h3, 32'(fan_alarm));
      chk("monitor_run", 32'h0, 32'(monitor_run));
      // Free-wheel test pauses monitoring, then clears itself
      wr(A_CTRL, 8'h18, OK);
      chk("fw_test_busy", 32'h1, 32'(fw_test_busy));
      chk("monitor_run", 32'h0, 32'(monitor_run));
      repeat (FW) @(posedge core_clk);
      rc("ctrl", A_CTRL, 8'h10, OK);
      chk("monitor_run", 32'h1, 32'(monitor_run));
      // Unmapped place answers with an error
      wr(8'h08, 8'hff, ERR);
      rc("unmapped", 8'h08, 8'h00, ERR);
      // Second power-up: auto off, diode 1 absent, diode 2 attached
      boot(3'h1);
      rc("ctrl", A_CTRL, 8'h00, OK);
      rc("fans", A_FANS, 8'h01, OK);
      rc("pin", A_PIN, 8'h1f, OK);
      chk("fan_alarm", 32'h3, 32'(fan_alarm));
      // Control bit 0 writes the fan-2 install bit
      wr(A_CTRL, 8'h01, OK);
      rc("fans", A_FANS, 8'h03, OK);
      summarize();
   end
endmodule
`default_nettype wire
